// [asbp_pkg.sv]
package asbp_pkg;

    // ************************************************************
    // widths
    // ************************************************************
    localparam int unsigned ADDR_W = 19;
    localparam int unsigned DATA_W = 8;

    // ************************************************************
    // timing (50 MHz clock)
    // ************************************************************
    localparam int unsigned CLK_PERIOD_NS   = 20;
    localparam int unsigned POWER_UP_WAIT_NS = 1000;
    localparam int unsigned POWER_UP_CYC =
        (POWER_UP_WAIT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int unsigned WRITE_DATA_SETUP_NS = 10;
    localparam int unsigned OUT_TURNOFF_NS      = 10;
    localparam int unsigned READ_ACCESS_NS      = 25;
    localparam int unsigned DESELECT_TO_RETENTION_DELAY_NS = 0;
    localparam int unsigned WR_CYC_RAW =
        (OUT_TURNOFF_NS + WRITE_DATA_SETUP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int unsigned RD_CYC_RAW =
        (READ_ACCESS_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS + 1;
    localparam int unsigned CNT_W = 6;
    localparam logic [CNT_W-1:0] POWER_UP_CNT = CNT_W'(POWER_UP_CYC);
    localparam logic [CNT_W-1:0] WR_CNT = CNT_W'(WR_CYC_RAW);
    localparam logic [CNT_W-1:0] RD_CNT = CNT_W'(RD_CYC_RAW);
    localparam logic [CNT_W-1:0] CNT_ZERO = 6'h00;
    localparam logic [CNT_W-1:0] CNT_ONE  = 6'h01;

    // ************************************************************
    // states, gray coded along power-up -> idle -> write -> write end; read, retention and the return to idle are not
    // ************************************************************
    typedef enum logic [2:0] {
        ASBP_PWRUP = 3'h0,
        ASBP_IDLE  = 3'h1,
        ASBP_WR    = 3'h3,
        ASBP_WREND = 3'h2,
        ASBP_RD    = 3'h6,
        ASBP_RET   = 3'h7
    } asbp_state_t;

endpackage : asbp_pkg

// [asbp_tmr_if.sv]
`timescale 1ns/1ps
interface asbp_tmr_if;
    logic                        load;
    logic [asbp_pkg::CNT_W-1:0]  value;
    logic                        done;
    modport ctl (output load, output value, input done);
    modport tmr (input load, input value, output done);
endinterface : asbp_tmr_if

// [asbp_timer.sv]
`timescale 1ns/1ps
module asbp_timer (
    // clock and reset
    input  wire logic clk_i,
    input  wire logic rst_i,
    input  wire logic en_i,
    // control
    asbp_tmr_if.tmr   t
);

    // ************************************************************
    // down counter, done when zero; leaves reset loaded with the power-up wait
    // ************************************************************
    logic [asbp_pkg::CNT_W-1:0] cnt_q;
    logic [asbp_pkg::CNT_W-1:0] cnt_d;

    assign cnt_d  = t.load ? t.value :
                    (cnt_q != asbp_pkg::CNT_ZERO) ? cnt_q - asbp_pkg::CNT_ONE : cnt_q;
    assign t.done = (cnt_q == asbp_pkg::CNT_ZERO) && !t.load;

    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            cnt_q <= asbp_pkg::POWER_UP_CNT;
        end else if (en_i) begin
            cnt_q <= cnt_d;
        end
    end

endmodule : asbp_timer

// [asbp_host.sv]
`timescale 1ns/1ps
module asbp_host (
    // clock and reset
    input  wire logic                        clk_i,
    input  wire logic                        rst_i,
    input  wire logic                        en_i,
    // user request
    input  wire logic                        req_i,
    input  wire logic                        we_i,
    input  wire logic [asbp_pkg::ADDR_W-1:0] addr_i,
    input  wire logic [asbp_pkg::DATA_W-1:0] wdata_i,
    input  wire logic                        ret_i,
    output logic                             ready_o,
    output logic                             rvalid_o,
    output logic [asbp_pkg::DATA_W-1:0]      rdata_o,
    output logic                             ret_o,
    // memory pins
    output logic                             ce_n_o,
    output logic                             oe_n_o,
    output logic                             we_n_o,
    output logic [asbp_pkg::ADDR_W-1:0]      addr_o,
    input  wire logic [asbp_pkg::DATA_W-1:0] data_pins_i,
    output logic [asbp_pkg::DATA_W-1:0]      data_pins_o,
    output logic                             data_pins_oe_o
);

    // ************************************************************
    // state and timer
    // ************************************************************
    asbp_pkg::asbp_state_t st_q;
    asbp_pkg::asbp_state_t st_d;
    asbp_tmr_if tmr ();

    asbp_timer u_timer (
        .clk_i (clk_i),
        .rst_i (rst_i),
        .en_i  (en_i),
        .t     (tmr)
    );

    wire take_wr = (st_q == asbp_pkg::ASBP_IDLE) && req_i && we_i && !ret_i;
    wire take_rd = (st_q == asbp_pkg::ASBP_IDLE) && req_i && !we_i && !ret_i;
    wire go_ret  = (st_q == asbp_pkg::ASBP_IDLE) && ret_i;

    // ************************************************************
    // next state
    // ************************************************************
    always_comb begin
        st_d       = st_q;
        tmr.load   = 1'b0;
        tmr.value  = asbp_pkg::CNT_ZERO;
        unique case (st_q)
            asbp_pkg::ASBP_PWRUP: begin
                if (tmr.done) st_d = asbp_pkg::ASBP_IDLE;
            end
            asbp_pkg::ASBP_IDLE: begin
                if (go_ret) begin
                    st_d = asbp_pkg::ASBP_RET;
                end else if (take_wr) begin
                    st_d      = asbp_pkg::ASBP_WR;
                    tmr.load  = 1'b1;
                    tmr.value = asbp_pkg::WR_CNT;
                end else if (take_rd) begin
                    st_d      = asbp_pkg::ASBP_RD;
                    tmr.load  = 1'b1;
                    tmr.value = asbp_pkg::RD_CNT;
                end
            end
            asbp_pkg::ASBP_WR: begin
                if (tmr.done) st_d = asbp_pkg::ASBP_WREND;
            end
            asbp_pkg::ASBP_WREND: st_d = asbp_pkg::ASBP_IDLE;
            asbp_pkg::ASBP_RD: begin
                if (tmr.done) st_d = asbp_pkg::ASBP_IDLE;
            end
            asbp_pkg::ASBP_RET: begin
                if (!ret_i) st_d = asbp_pkg::ASBP_IDLE;
            end
            default: st_d = asbp_pkg::ASBP_IDLE;
        endcase
    end

    // ************************************************************
    // pin values
    // ************************************************************
    wire in_wr    = (st_d == asbp_pkg::ASBP_WR);
    wire in_rd    = (st_d == asbp_pkg::ASBP_RD);
    wire wr_hold  = (st_d == asbp_pkg::ASBP_WREND);
    wire ce_n_d   = !(in_wr || in_rd);
    wire oe_n_d   = !in_rd;
    wire we_n_d   = !in_wr;
    wire drv_d    = in_wr || wr_hold;
    wire rd_done  = (st_q == asbp_pkg::ASBP_RD) && tmr.done;

    // ************************************************************
    // check helper: enabled edges since reset, saturating
    // ************************************************************
    logic [asbp_pkg::CNT_W-1:0] up_edges_q;
    wire                        up_full = (up_edges_q == asbp_pkg::POWER_UP_CNT);

    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            up_edges_q <= asbp_pkg::CNT_ZERO;
        end else if (en_i && !up_full) begin
            up_edges_q <= up_edges_q + asbp_pkg::CNT_ONE;
        end
    end

    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            st_q           <= asbp_pkg::ASBP_PWRUP;
            ce_n_o         <= 1'b1;
            oe_n_o         <= 1'b1;
            we_n_o         <= 1'b1;
            data_pins_oe_o <= 1'b0;
        end else if (en_i) begin
            st_q           <= st_d;
            ce_n_o         <= ce_n_d;
            oe_n_o         <= oe_n_d;
            we_n_o         <= we_n_d;
            data_pins_oe_o <= drv_d;
        end
    end

    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            addr_o      <= '0;
            data_pins_o <= '0;
            rdata_o     <= '0;
            rvalid_o    <= 1'b0;
            ready_o     <= 1'b0;
            ret_o       <= 1'b0;
        end else if (en_i) begin
            if (take_wr || take_rd) begin
                addr_o <= addr_i;
            end
            if (take_wr) begin
                data_pins_o <= wdata_i;
            end
            if (rd_done) begin
                rdata_o <= data_pins_i;
            end
            rvalid_o <= rd_done;
            ready_o  <= (st_d == asbp_pkg::ASBP_IDLE) && !ret_i;
            ret_o    <= (st_d == asbp_pkg::ASBP_RET);
        end
    end

    // ************************************************************
    // checks
    // ************************************************************
    a_no_bus_fight: assert property (@(posedge clk_i) disable iff (rst_i)
        data_pins_oe_o |-> oe_n_o)
        else $error("host drives data while output enable low");

    a_write_data_hold: assert property (@(posedge clk_i) disable iff (rst_i)
        (!we_n_o && en_i) ##1 we_n_o |-> data_pins_oe_o && $stable(data_pins_o))
        else $error("write data not held past write end");

    a_write_length: assert property (@(posedge clk_i) disable iff (rst_i)
        ($fell(we_n_o) && en_i) ##1 en_i |-> !we_n_o)
        else $error("write pulse too short");

    a_write_ends_both: assert property (@(posedge clk_i) disable iff (rst_i)
        $rose(we_n_o) |-> $rose(ce_n_o))
        else $error("write not ended by strobe rise");

    a_read_we_high: assert property (@(posedge clk_i) disable iff (rst_i)
        !oe_n_o |-> we_n_o && !ce_n_o && ($stable(addr_o) || $fell(oe_n_o)))
        else $error("read with write enable low or address moving");

    a_power_up_gap: assert property (@(posedge clk_i) disable iff (rst_i)
        !ce_n_o |-> up_full)
        else $error("strobe before power-up wait ran out");

    a_turnaround_gap: assert property (@(posedge clk_i) disable iff (rst_i)
        $rose(data_pins_oe_o) |-> $past(oe_n_o))
        else $error("host drives data right after a read");

    a_rvalid_pulse: assert property (@(posedge clk_i) disable iff (rst_i)
        rvalid_o && en_i |=> !rvalid_o)
        else $error("read valid longer than one cycle");

    a_retention_hold: assert property (@(posedge clk_i) disable iff (rst_i)
        ret_o && ret_i && en_i |=> ret_o && ce_n_o)
        else $error("retention left while still requested");

    a_write_addr_hold: assert property (@(posedge clk_i) disable iff (rst_i)
        !we_n_o && !$fell(we_n_o) |-> $stable(addr_o) && $stable(data_pins_o))
        else $error("address or data moved inside the write window");

    a_select_strobes: assert property (@(posedge clk_i) disable iff (rst_i)
        $fell(ce_n_o) && we_n_o |-> !oe_n_o)
        else $error("select fell without a read or write");

    a_retention_desel: assert property (@(posedge clk_i) disable iff (rst_i)
        ret_o |-> ce_n_o)
        else $error("selected during retention");

    a_power_wait: assert property (@(posedge clk_i) disable iff (rst_i)
        (st_q == asbp_pkg::ASBP_PWRUP) |-> ce_n_o && !ready_o)
        else $error("access before power-up wait");

    a_write_window: assert property (@(posedge clk_i) disable iff (rst_i)
        !we_n_o |-> !ce_n_o && oe_n_o)
        else $error("write enable low without select");

endmodule : asbp_host

// [asbp_sram_model.sv]
`timescale 1ns/1ps
module asbp_sram_model (
    // strobes and address
    input  wire logic                        ce_n_i,
    input  wire logic                        oe_n_i,
    input  wire logic                        we_n_i,
    input  wire logic [asbp_pkg::ADDR_W-1:0] addr_i,
    // data bus
    input  wire logic [asbp_pkg::DATA_W-1:0] data_i,
    output logic      [asbp_pkg::DATA_W-1:0] data_o,
    output logic                             drv_o
);
    logic [7:0] mem [logic [18:0]];
    logic [7:0] last_q = 8'h00;
    wire        win    = !ce_n_i && !we_n_i;
    // store at the first rising strobe of the overlap
    always @(negedge win) mem[addr_i] = data_i;
    always @(ce_n_i or oe_n_i or we_n_i or addr_i or win) begin
        drv_o = !ce_n_i && !oe_n_i && we_n_i;
        if (drv_o) begin
            data_o = mem.exists(addr_i) ? mem[addr_i] : 8'h00;
            last_q = data_o;
        end else begin
            // released bus shows no stale byte
            data_o = ~last_q;
        end
    end
endmodule : asbp_sram_model

// [async_sram_byte_port_tb.sv]
`timescale 1ns/1ps
module async_sram_byte_port_tb;
    logic        clk_i, rst_i, en_i, req_i, we_i, ret_i;
    logic [18:0] addr_i;
    logic [7:0]  wdata_i;
    logic        ready_o, rvalid_o, ret_o, ce_n_o, oe_n_o, we_n_o, pins_oe, m_drv;
    logic [18:0] addr_o;
    logic [7:0]  rdata_o, pins_o, m_data;
    wire  [7:0]  bus = pins_oe ? pins_o : m_data;
    int          failures = 0;
    int          n_tests = 0;
    int          i;
    logic [31:0] lfsr_q = 32'd47;
    logic [7:0]  ref_m [logic [18:0]];
    logic [18:0] wq [$];
    asbp_host dut (.clk_i(clk_i), .rst_i(rst_i), .en_i(en_i), .req_i(req_i), .we_i(we_i),
        .addr_i(addr_i), .wdata_i(wdata_i), .ret_i(ret_i), .ready_o(ready_o),
        .rvalid_o(rvalid_o), .rdata_o(rdata_o), .ret_o(ret_o), .ce_n_o(ce_n_o),
        .oe_n_o(oe_n_o), .we_n_o(we_n_o), .addr_o(addr_o), .data_pins_i(bus),
        .data_pins_o(pins_o), .data_pins_oe_o(pins_oe));
    asbp_sram_model mdl (.ce_n_i(ce_n_o), .oe_n_i(oe_n_o), .we_n_i(we_n_o),
        .addr_i(addr_o), .data_i(bus), .data_o(m_data), .drv_o(m_drv));
    always #10 clk_i = ~clk_i;
    // ************************************************************
    // helpers
    // ************************************************************
    function automatic logic [31:0] rnd();
        repeat (19) lfsr_q = {lfsr_q[30:0], lfsr_q[31] ^ lfsr_q[21] ^ lfsr_q[1] ^ lfsr_q[0]};
        return lfsr_q;
    endfunction : rnd
    function automatic void chk(string what, logic [31:0] exp, logic [31:0] got);
        n_tests++;
        if (got !== exp) begin
            failures++;
            $display("wrong value %s expected %0h seen %0h", what, exp, got);
        end
    endfunction : chk
    task automatic tick();
        @(posedge clk_i);
        #2;
    endtask : tick
    task automatic op(input logic w, input logic [18:0] a, input logic [7:0] d);
        int k;
        k = 0;
        while (ready_o !== 1'b1 && k < 100) begin
            tick();
            k++;
        end
        chk("ready", 1, ready_o);
        req_i = 1'b1;
        we_i = w;
        addr_i = a;
        wdata_i = d;
        tick();
        // req_i dropped, address and write data scrambled, en_i sometimes held low one cycle after the take
        req_i = 1'b0;
        addr_i = 19'(rnd());
        wdata_i = 8'(rnd());
        if (rnd() % 2 == 1) begin
            en_i = 1'b0;
            tick();
            en_i = 1'b1;
        end
        if (w) begin
            ref_m[a] = d;
        end else begin
            k = 0;
            while (rvalid_o !== 1'b1 && k < 20) begin
                tick();
                k++;
            end
            chk("rvalid", 1, rvalid_o);
            chk("rdata", ref_m.exists(a) ? ref_m[a] : 8'h00, rdata_o);
        end
    endtask : op
    task stop_test;
        $display("checks %0d failures %0d", n_tests, failures);
        if (failures == 0 && n_tests > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask : stop_test
    // ************************************************************
    // bus watch and sequence
    // ************************************************************
    always @(negedge clk_i) begin
        if (!rst_i && pins_oe === 1'b1 && m_drv === 1'b1) chk("bus clash", 0, 1);
        if (!rst_i && ret_o === 1'b1) chk("ret ce_n", 1, ce_n_o);
    end
    initial begin
        #400000;
        failures++;
        $display("watchdog expired");
        stop_test();
    end
    initial begin
        clk_i = 1'b0;
        rst_i = 1'b1;
        en_i = 1'b1;
        req_i = 1'b0;
        we_i = 1'b0;
        ret_i = 1'b0;
        addr_i = 19'h00000;
        wdata_i = 8'h00;
        repeat (3) tick();
        rst_i = 1'b0;
        for (i = 0; i < asbp_pkg::POWER_UP_CYC - 1; i++) begin
            chk("pwrup ce_n", 1, ce_n_o);
            chk("pwrup ready", 0, ready_o);
            tick();
        end
        op(1'b1, 19'h00000, 8'h5A);
        op(1'b1, 19'h7FFFF, 8'hC3);
        for (i = 0; i < 40; i++) begin
            wq.push_back(19'(rnd()));
            op(1'b1, wq[i], 8'(rnd()));
        end
        op(1'b1, wq[0], 8'hFF);
        op(1'b0, 19'h00000, 8'h00);
        op(1'b0, 19'h7FFFF, 8'h00);
        foreach (wq[j]) op(1'b0, wq[j], 8'h00);
        ret_i = 1'b1;
        i = 0;
        while (ret_o !== 1'b1 && i < 50) begin
            tick();
            i++;
        end
        chk("ret_o", 1, ret_o);
        repeat (5) tick();
        ret_i = 1'b0;
        op(1'b0, wq[1], 8'h00);
        stop_test();
    end
endmodule : async_sram_byte_port_tb
